// ==== logic/modem_ctl_pkg.sv ====
// package for the synchronous modem control block: timing constants and states
// assumes a single 20 MHz system clock; all times are converted here
package modem_ctl_pkg;
	localparam int CLK_HZ = 20000000;
	// self-test indicator timing
	localparam int PASS_DEADLINE_S = 15; // led must be out by this time
	localparam int PASS_DEADLINE_CYC = PASS_DEADLINE_S * CLK_HZ;
	localparam int FLASH_HALF_MS = 250; // half period of the error flash
	localparam int FLASH_HALF_CYC = FLASH_HALF_MS * (CLK_HZ / 1000);
	// synchroniser depth for pin inputs
	localparam int SYNC_STAGES = 3;
	typedef enum logic [1:0] {
		TX_IDLE,
		TX_WAIT_CTS,
		TX_SEND,
		TX_DRAIN
	} tx_state_t;
	typedef enum logic [1:0] {
		LED_TESTING,
		LED_OFF,
		LED_STEADY,
		LED_FLASH
	} led_state_t;
endpackage

// ==== logic/pin_sync.sv ====
// three-stage synchroniser for one pin input with agreement filter
// assumes the pin is asynchronous to mclk; output changes once stages two and three agree
module pin_sync #(
	parameter logic RESET_VAL = 1'b0
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic pinIn,
	output logic level,
	output logic rise,
	output logic fall
);
	logic [2:0] stage_r;
	logic level_r;

	// first stage feeds only the second one
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			stage_r <= {3{RESET_VAL}};
		end else begin
			stage_r <= {stage_r[1:0], pinIn};
		end
	end

	// accept a change only when the two later stages agree, filters a single glitch
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			level_r <= RESET_VAL;
		end else if (stage_r[1] == stage_r[2]) begin
			level_r <= stage_r[2];
		end
	end

	assign level = level_r;
	assign rise = (stage_r[1] == stage_r[2]) && stage_r[2] && !level_r;
	assign fall = (stage_r[1] == stage_r[2]) && !stage_r[2] && level_r;
endmodule // pin_sync

// ==== logic/modem_ctl.sv ====
// data terminal side of a synchronous modem link plus the self-test indicator led
// assumes modem pins are asynchronous to mclk; transmit and receive timing come from
// the modem and are sampled, not used as clocks; test results come from local logic

// Operation
// - when all self tests pass the led goes out before fifteen seconds and boot starts.
// - on a catastrophic failure the led stays lit past fifteen seconds.
// - on a reportable failure the led flashes instead of staying on or off.
// - transmit data leaves only while clear-to-send, terminal-ready and set-ready are on.
// - request-to-send is raised first and data is held until clear-to-send comes on.
// - terminal-ready is held on continuously while the link is in use.
// - received data is sampled on the falling edge of receive timing, mid bit.
module modem_ctl #(
	parameter int PASS_CYC = modem_ctl_pkg::PASS_DEADLINE_CYC,
	parameter int FLASH_CYC = modem_ctl_pkg::FLASH_HALF_CYC,
	parameter int WIDTH = 8
) (
	input wire logic mclk,
	input wire logic rst_b,
	// self-test results from the local test logic
	input wire logic testDone,
	input wire logic testCatastrophic,
	input wire logic testReportable,
	output logic ledOn,
	output logic bootStart,
	// user side
	input wire logic linkEnable,
	input wire logic txValid,
	input wire logic [WIDTH-1:0] txData,
	output logic txReady,
	output logic [WIDTH-1:0] rxData,
	output logic rxValid,
	output logic modemReady,
	output logic carrierOn,
	// modem pins
	output logic termReady,
	output logic reqSend,
	output logic txLine,
	input wire logic clearSend,
	input wire logic setReady,
	input wire logic carrierDet,
	input wire logic rxLine,
	input wire logic txTiming,
	input wire logic rxTiming
);
	localparam int CW = $clog2(WIDTH + 1);
	logic ctsLvl, dsrLvl, dcdLvl, rxdLvl, txtFall, rxtFall;
	modem_ctl_pkg::tx_state_t txState_r;
	modem_ctl_pkg::led_state_t ledState_r;
	logic [WIDTH-1:0] txShift_r, rxShift_r, rxData_r;
	logic [CW-1:0] txCount_r, rxCount_r;
	logic rxValid_r, txLine_r, termReady_r, bootStart_r, ledOn_r, flashPhase_r;
	logic [31:0] ledTimer_r, flashTimer_r;
	logic linkOk;

	// one synchroniser per modem input; data idles at mark (1)
	pin_sync #(.RESET_VAL(1'b0)) syncCts (.mclk(mclk), .rst_b(rst_b), .pinIn(clearSend),
		.level(ctsLvl), .rise(), .fall());
	pin_sync #(.RESET_VAL(1'b0)) syncDsr (.mclk(mclk), .rst_b(rst_b), .pinIn(setReady),
		.level(dsrLvl), .rise(), .fall());
	pin_sync #(.RESET_VAL(1'b0)) syncDcd (.mclk(mclk), .rst_b(rst_b), .pinIn(carrierDet),
		.level(dcdLvl), .rise(), .fall());
	pin_sync #(.RESET_VAL(1'b1)) syncRxd (.mclk(mclk), .rst_b(rst_b), .pinIn(rxLine),
		.level(rxdLvl), .rise(), .fall());
	pin_sync #(.RESET_VAL(1'b0)) syncTxt (.mclk(mclk), .rst_b(rst_b), .pinIn(txTiming),
		.level(), .rise(), .fall(txtFall));
	pin_sync #(.RESET_VAL(1'b0)) syncRxt (.mclk(mclk), .rst_b(rst_b), .pinIn(rxTiming),
		.level(), .rise(), .fall(rxtFall));

	// terminal ready follows the user enable and is held steady while enabled
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			termReady_r <= 1'b0;
		end else begin
			termReady_r <= linkEnable;
		end
	end

	// all three conditions must stand before any bit leaves
	assign linkOk = ctsLvl && dsrLvl && termReady_r;

	// transmit sequencer: raise rts, wait for cts, shift bytes on timing edges
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			txState_r <= modem_ctl_pkg::TX_IDLE;
			txShift_r <= '0;
			txCount_r <= '0;
			txLine_r <= 1'b1;
		end else begin
			case (txState_r)
				modem_ctl_pkg::TX_IDLE: begin
					txLine_r <= 1'b1;
					// a cts left up from the last request must fall first, or it would pass
					// as the answer to the next one; a modem with cts strapped on never gets one
					if (txValid && termReady_r && dsrLvl && !ctsLvl) begin
						txState_r <= modem_ctl_pkg::TX_WAIT_CTS;
					end
				end
				modem_ctl_pkg::TX_WAIT_CTS: begin
					txLine_r <= 1'b1; // no data until cts
					if (!termReady_r || !dsrLvl) begin
						txState_r <= modem_ctl_pkg::TX_IDLE;
					end else if (ctsLvl && txValid) begin
						txShift_r <= txData;
						txCount_r <= CW'(WIDTH);
						txState_r <= modem_ctl_pkg::TX_SEND;
					end
				end
				modem_ctl_pkg::TX_SEND: begin
					if (!linkOk) begin
						txLine_r <= 1'b1;
						txState_r <= modem_ctl_pkg::TX_IDLE;
					end else if (txtFall) begin
						// new bit presented on the falling timing edge, modem samples on the next fall
						txLine_r <= txShift_r[0];
						txShift_r <= txShift_r >> 1;
						txCount_r <= txCount_r - 1'b1;
						if (txCount_r == CW'(1)) begin
							txState_r <= modem_ctl_pkg::TX_DRAIN;
						end
					end
				end
				modem_ctl_pkg::TX_DRAIN: begin
					// hold the last bit one more timing period, then chain or release
					if (!linkOk) begin
						txLine_r <= 1'b1;
						txState_r <= modem_ctl_pkg::TX_IDLE;
					end else if (txtFall) begin
						txLine_r <= 1'b1;
						txState_r <= modem_ctl_pkg::TX_IDLE;
					end else if (txValid) begin
						txShift_r <= txData;
						txCount_r <= CW'(WIDTH);
						txState_r <= modem_ctl_pkg::TX_SEND;
					end
				end
				default: txState_r <= modem_ctl_pkg::TX_IDLE;
			endcase
		end
	end

	assign txReady = ((txState_r == modem_ctl_pkg::TX_WAIT_CTS) && ctsLvl && dsrLvl
		&& termReady_r) || ((txState_r == modem_ctl_pkg::TX_DRAIN) && linkOk && !txtFall);

	// receiver: sample mid bit on the on-to-off edge of receive timing while carrier is up
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rxShift_r <= '0;
			rxCount_r <= '0;
			rxData_r <= '0;
			rxValid_r <= 1'b0;
		end else begin
			rxValid_r <= 1'b0;
			if (!dcdLvl || reqSend) begin
				rxCount_r <= '0; // receiver is off while carrier is down or rts is up
			end else if (rxtFall) begin
				rxShift_r <= {rxdLvl, rxShift_r[WIDTH-1:1]};
				if (rxCount_r == CW'(WIDTH - 1)) begin
					rxData_r <= {rxdLvl, rxShift_r[WIDTH-1:1]};
					rxValid_r <= 1'b1;
					rxCount_r <= '0;
				end else begin
					rxCount_r <= rxCount_r + 1'b1;
				end
			end
		end
	end

	// self-test indicator: lit from reset until a verdict, then off, steady or flashing
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			ledState_r <= modem_ctl_pkg::LED_TESTING;
			ledTimer_r <= '0;
			bootStart_r <= 1'b0;
		end else begin
			bootStart_r <= 1'b0;
			case (ledState_r)
				modem_ctl_pkg::LED_TESTING: begin
					if (testCatastrophic) begin
						ledState_r <= modem_ctl_pkg::LED_STEADY;
					end else if (testReportable) begin
						ledState_r <= modem_ctl_pkg::LED_FLASH;
					end else if (testDone) begin
						ledState_r <= modem_ctl_pkg::LED_OFF;
						bootStart_r <= 1'b1;
					end else if (ledTimer_r >= 32'(PASS_CYC - 1)) begin
						// no verdict by the deadline counts as catastrophic
						ledState_r <= modem_ctl_pkg::LED_STEADY;
					end else begin
						ledTimer_r <= ledTimer_r + 32'h1;
					end
				end
				default: ledState_r <= ledState_r; // verdicts are final until reset
			endcase
		end
	end

	// flash timebase, only runs in the flash state
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			flashTimer_r <= '0;
			flashPhase_r <= 1'b1;
		end else if (ledState_r != modem_ctl_pkg::LED_FLASH) begin
			flashTimer_r <= '0;
			flashPhase_r <= 1'b1;
		end else if (flashTimer_r >= 32'(FLASH_CYC - 1)) begin
			flashTimer_r <= '0;
			flashPhase_r <= !flashPhase_r;
		end else begin
			flashTimer_r <= flashTimer_r + 32'h1;
		end
	end

	// led register
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			ledOn_r <= 1'b1;
		end else begin
			case (ledState_r)
				modem_ctl_pkg::LED_OFF: ledOn_r <= 1'b0;
				modem_ctl_pkg::LED_FLASH: ledOn_r <= flashPhase_r;
				default: ledOn_r <= 1'b1;
			endcase
		end
	end

	assign ledOn = ledOn_r;
	assign bootStart = bootStart_r;
	assign termReady = termReady_r;
	assign reqSend = (txState_r != modem_ctl_pkg::TX_IDLE);
	assign txLine = txLine_r;
	assign rxData = rxData_r;
	assign rxValid = rxValid_r;
	assign modemReady = dsrLvl;
	assign carrierOn = dcdLvl;
endmodule // modem_ctl

// ==== verification/modem_ctl_chk.sv ====
// checker: port timing of modem_ctl
// assumes a bind to modem_ctl, mclk rising, rst_b low active
module modem_ctl_chk (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic testCatastrophic,
	input wire logic ledOn,
	input wire logic bootStart,
	input wire logic linkEnable,
	input wire logic txReady,
	input wire logic rxValid,
	input wire logic modemReady,
	input wire logic carrierOn,
	input wire logic termReady,
	input wire logic reqSend,
	input wire logic txLine,
	input wire logic clearSend
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_b);
	// led verdicts
	property p_pass; bootStart |=> !ledOn [*8]; endproperty
	a_pass: assert property (p_pass) else $error("led lit after pass");
	property p_cat; testCatastrophic [*3] |-> ledOn; endproperty
	a_cat: assert property (p_cat) else $error("led dark on failure");
	property p_flash; $rose(ledOn) |-> ##[1:40] !ledOn; endproperty
	a_flash: assert property (p_flash) else $error("flash stuck");
	// cts looked at two edges back, since the pin passes a synchroniser
	property p_gate; txReady |-> termReady && modemReady && reqSend; endproperty
	a_gate: assert property (p_gate) else $error("byte taken while off");
	property p_mark; !reqSend |-> txLine; endproperty
	a_mark: assert property (p_mark) else $error("data without rts");
	property p_cts; txReady |-> $past(clearSend, 2); endproperty
	a_cts: assert property (p_cts) else $error("byte before cts");
	property p_dtr; linkEnable [*2] |-> termReady; endproperty
	a_dtr: assert property (p_dtr) else $error("dtr not held");
	property p_rx; rxValid |-> $past(carrierOn) && !$past(reqSend); endproperty
	a_rx: assert property (p_rx) else $error("rx while off");
endmodule // modem_ctl_chk

bind modem_ctl modem_ctl_chk i_chk (.mclk, .rst_b, .testCatastrophic, .ledOn, .bootStart,
	.linkEnable, .txReady, .rxValid, .modemReady, .carrierOn, .termReady, .reqSend, .txLine,
	.clearSend);

// ==== verification/sync_modem_model.sv ====
// behavioural synchronous modem facing modem_ctl
// assumes mclk paces only the cts delay; timing pins run on their own
module sync_modem_model #(
	parameter int CTS_CYC = 30
) (
	input wire logic mclk,
	input wire logic termReady,
	input wire logic reqSend,
	input wire logic txLine,
	input wire logic rxStart,
	input wire logic [7:0] rxByte,
	output logic clearSend,
	output logic setReady,
	output logic carrierDet,
	output logic rxLine,
	output logic txTiming,
	output logic rxTiming,
	output logic [15:0] txCapt
);
	timeunit 1ns;
	timeprecision 1ns;
	int ctsCnt = 0;
	logic carrier = 1'b0;
	// carrier detect and the receiver are off while the terminal requests to send
	assign carrierDet = carrier && !reqSend;
	// data mode only while terminal ready is on
	assign setReady = termReady;
	initial begin
		clearSend = 1'b0;
		rxLine = 1'b1;
		rxTiming = 1'b0;
		txTiming = 1'b0;
		txCapt = 16'hffff;
	end
	// transmit timing runs free, off the mclk phase
	always #200 txTiming = ~txTiming;
	// cts answers rts after a scaled delay, drops with it
	always @(posedge mclk) begin
		if (!reqSend) begin
			ctsCnt <= 0;
			clearSend <= 1'b0;
		end else if (ctsCnt == CTS_CYC) begin
			clearSend <= 1'b1;
		end else begin
			ctsCnt <= ctsCnt + 1;
		end
	end
	// bit taken as its period closes
	always @(negedge txTiming) if (reqSend) txCapt <= {txLine, txCapt[15:1]};
	// one frame: carrier, eight timed bits, carrier off; timing still outside
	always @(posedge rxStart) begin
		#7 carrier = 1'b1;
		#400;
		for (int i = 0; i < 8; i++) begin
			rxTiming = 1'b1;
			rxLine = rxByte[i];
			#200 rxTiming = 1'b0;
			#200;
		end
		carrier = 1'b0;
		rxLine = 1'b1;
	end
endmodule // sync_modem_model

// ==== verification/testbench.sv ====
// self-checking bench for modem_ctl with a behavioural modem
// assumes modem_ctl and sync_modem_model are compiled first
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk = 1'b0, rst_b = 1'b0, testDone = 1'b0, testCatastrophic = 1'b0, lp;
	logic testReportable = 1'b0, linkEnable = 1'b0, txValid = 1'b0, rxStart = 1'b0;
	logic [7:0] txData = 8'h00, rxByte = 8'h00, rxData, b0, b1;
	logic ledOn, bootStart, txReady, rxValid, modemReady, carrierOn, termReady, reqSend;
	logic txLine, clearSend, setReady, carrierDet, rxLine, txTiming, rxTiming;
	logic [15:0] txCapt;
	int n_errors = 0, compares = 0, seed = 32'h2d6d, tog, boots;
	always #25 mclk = ~mclk;
	modem_ctl #(.PASS_CYC(200), .FLASH_CYC(10)) i_modem_ctl (.mclk, .rst_b, .testDone,
		.testCatastrophic, .testReportable, .ledOn, .bootStart, .linkEnable, .txValid, .txData,
		.txReady, .rxData, .rxValid, .modemReady, .carrierOn, .termReady, .reqSend, .txLine,
		.clearSend, .setReady, .carrierDet, .rxLine, .txTiming, .rxTiming);
	sync_modem_model i_sync_modem_model (.mclk, .termReady, .reqSend, .txLine, .rxStart,
		.rxByte, .clearSend, .setReady, .carrierDet, .rxLine, .txTiming, .rxTiming, .txCapt);
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test();
		$display("compares %0d errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic doReset();
		rst_b = 1'b0;
		repeat (6) @(negedge mclk);
		rst_b = 1'b1;
	endtask
	// expected {led, boot pulses, flashing} for pass, fatal, flash, no verdict
	function automatic logic [11:0] ledExp(input int k);
		return k == 0 ? 12'h010 : k == 2 ? 12'h001 : 12'h100;
	endfunction
	// bounded wait on txReady, rxValid or reqSend, seen at the falling edge where they settle
	task automatic waitFor(input int w, input logic want, input int lim);
		int k;
		for (k = 0; k < lim; k++) begin
			@(negedge mclk);
			if ((w == 0 ? txReady : w == 1 ? rxValid : reqSend) === want) break;
		end
		if (k == lim) begin
			n_errors++;
			$display("ERROR %0t: wait timed out", $time);
			end_of_test();
		end
	endtask
	initial begin
		// each verdict from a fresh reset, at a random moment
		for (int k = 0; k < 4; k++) begin
			// clear the last verdict first, or it is taken right after reset
			{testDone, testCatastrophic, testReportable} = 3'h0;
			doReset();
			repeat ($unsigned(6'($random(seed)))) @(negedge mclk);
			testDone = (k == 0);
			testCatastrophic = (k == 1);
			testReportable = (k == 2);
			tog = 0;
			boots = 0;
			repeat (300) begin
				lp = ledOn;
				@(negedge mclk);
				tog += (ledOn != lp);
				boots += bootStart;
			end
			check({4'h0, k == 2 ? 4'h0 : {3'h0, ledOn}, 4'(boots), 3'h0, tog > 20},
				{4'h0, ledExp(k)});
			$display("led case %0d done", k);
		end
		// refused while terminal not ready, then back-to-back bytes
		testDone = 1'b1;
		testCatastrophic = 1'b0;
		testReportable = 1'b0;
		doReset();
		txValid = 1'b1;
		repeat (40) @(negedge mclk);
		check({14'h0, reqSend, termReady}, 16'h0000);
		linkEnable = 1'b1;
		for (int r = 0; r < 3; r++) begin
			b0 = 8'($random(seed));
			b1 = 8'($random(seed));
			txData = b0;
			txValid = 1'b1;
			waitFor(0, 1'b1, 200);
			@(negedge mclk) txData = b1;
			waitFor(0, 1'b1, 200);
			@(negedge mclk) txValid = 1'b0;
			waitFor(2, 1'b0, 200);
			check(txCapt, {b1, b0});
		end
		$display("transmit done");
		for (int r = 0; r < 3; r++) begin
			@(negedge mclk) rxByte = 8'($random(seed));
			rxStart = 1'b1;
			waitFor(1, 1'b1, 300);
			check({8'h00, rxData}, {8'h00, rxByte});
			check({14'h0, modemReady, carrierOn}, 16'h0003);
			@(negedge mclk) rxStart = 1'b0;
			repeat (20) @(negedge mclk);
		end
		$display("receive done");
		end_of_test();
	end
endmodule // testbench
